/* File: rtl/icmc_core.sv */
// input capture mode control: edge select, prescale, capture buffer, status and interrupt
`timescale 1ns/1ps
module icmc_core
	import icmc_pkg::*;
#(
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// register port
	input  wire logic [3:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [15:0] rdata_o,
	// capture input, timebase ticks, sync/trigger source, sleep state
	input  wire logic        cap_in_i,
	input  wire logic        tclk1_tick_i,
	input  wire logic        tclk2_tick_i,
	input  wire logic        sync_src_i,
	input  wire logic        sleep_i,
	// interrupts
	output logic             irq_o,
	output logic             wake_o
);

	if (DEPTH != 4) begin : g_depth_check
		$error("icmc_core: DEPTH must be 4");
	end

	icmc_state_s r;
	icmc_state_s next_r;
	logic [15:0] buf_mem [DEPTH];
	icmc_bus_s   bus;
	logic        rise, fall, cap, tick, bne, do_pop, do_push, nfull;
	logic [ICMC_EV_W-1:0] ev_set;

	assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

	always_comb begin
		next_r = r;
		ev_set = '0;
		rise = cap_in_i & ~r.in_d;
		fall = ~cap_in_i & r.in_d;
		next_r.in_d = cap_in_i;
		bne = r.cnt != 3'h0;
		nfull = r.cnt != 3'(DEPTH);
		do_pop = bus.rd && bus.addr == ICMC_IDX_BUF && bne;
		cap = 1'b0;
		next_r.wake = 1'b0;
		// edge selection and prescale
		unique case (r.mode)
			ICMC_M_BOTH: cap = rise | fall;
			ICMC_M_FALL: cap = fall;
			ICMC_M_RISE: cap = rise;
			ICMC_M_RISE4, ICMC_M_RISE16: begin
				if (rise) begin
					next_r.pre = r.pre + 4'h1;
					if (r.pre == ((r.mode == ICMC_M_RISE4) ? ICMC_PRE4_LAST : ICMC_PRE16_LAST)) begin
						cap = 1'b1;
						next_r.pre = 4'h0;
					end
				end
			end
			ICMC_M_WAKE: next_r.wake = rise & sleep_i;
			default: cap = 1'b0;
		endcase
		// timebase tick
		unique case (r.tsel)
			ICMC_TB_PERIPH: tick = 1'b1;
			ICMC_TB_TCLK1:  tick = tclk1_tick_i;
			ICMC_TB_TCLK2:  tick = tclk2_tick_i;
			default:        tick = 1'b0;
		endcase
		// trigger or sync of the capture timer
		if (r.trig) begin
			if (sync_src_i) next_r.tstat = 1'b1;
			if (!r.tstat) next_r.timer = 16'h0000;
			else if (tick) next_r.timer = r.timer + 16'h0001;
		end else if (sync_src_i) begin
			next_r.timer = 16'h0000;
		end else if (tick) begin
			next_r.timer = r.timer + 16'h0001;
		end
		// buffer push with overflow
		do_push = cap && nfull;
		if (cap && !nfull) next_r.ovf = 1'b1;
		if (do_push) next_r.wp = r.wp + 2'h1;
		if (do_pop) next_r.rp = r.rp + 2'h1;
		next_r.cnt = r.cnt + 3'(do_push) - 3'(do_pop);
		// captures per interrupt
		if (cap) begin
			if (r.mode == ICMC_M_BOTH || r.irqcnt == r.cpi) begin
				next_r.irqcnt = 2'h0;
				ev_set[ICMC_EV_CAPIRQ] = 1'b1;
			end else begin
				next_r.irqcnt = r.irqcnt + 2'h1;
			end
		end
		ev_set[ICMC_EV_OVF] = cap && !nfull;
		ev_set[ICMC_EV_WAKE] = next_r.wake;
		next_r.stat = r.stat | ev_set;
		// register writes; a status clear loses to a same-cycle set
		if (bus.wr) begin
			unique case (bus.addr)
				ICMC_IDX_CON1: begin
					next_r.mode = bus.wdata[ICMC_MODE_LSB +: 3];
					next_r.cpi  = bus.wdata[ICMC_CPI_LSB +: 2];
					next_r.tsel = bus.wdata[ICMC_TSEL_LSB +: 3];
					if (bus.wdata[ICMC_MODE_LSB +: 3] == ICMC_M_OFF) begin
						next_r.ovf = 1'b0;
						next_r.cnt = 3'h0;
						next_r.wp = 2'h0;
						next_r.rp = 2'h0;
						next_r.pre = 4'h0;
						next_r.irqcnt = 2'h0;
					end
				end
				ICMC_IDX_CON2: begin
					next_r.trig = bus.wdata[ICMC_TRIG_BIT];
					next_r.tstat = bus.wdata[ICMC_TSTAT_BIT] | (r.trig & sync_src_i);
				end
				ICMC_IDX_STATUS: next_r.stat = next_r.stat & ~(bus.wdata[ICMC_EV_W-1:0] & ~ev_set);
				ICMC_IDX_MASK:   next_r.mask = bus.wdata[ICMC_EV_W-1:0];
				default: ;
			endcase
		end
		// overflow clears once the buffer is drained
		if (do_pop && r.cnt == 3'h1 && !cap) next_r.ovf = 1'b0;
		// read data, one cycle later
		next_r.rdata = 16'h0000;
		if (bus.rd) begin
			unique case (bus.addr)
				ICMC_IDX_CON1: begin
					next_r.rdata[ICMC_MODE_LSB +: 3] = r.mode;
					next_r.rdata[ICMC_BNE_BIT] = bne;
					next_r.rdata[ICMC_OVF_BIT] = r.ovf;
					next_r.rdata[ICMC_CPI_LSB +: 2] = r.cpi;
					next_r.rdata[ICMC_TSEL_LSB +: 3] = r.tsel;
				end
				ICMC_IDX_CON2: begin
					next_r.rdata[ICMC_TRIG_BIT] = r.trig;
					next_r.rdata[ICMC_TSTAT_BIT] = r.tstat;
				end
				ICMC_IDX_BUF:    next_r.rdata = bne ? buf_mem[r.rp] : 16'h0000;
				ICMC_IDX_STATUS: next_r.rdata[ICMC_EV_W-1:0] = r.stat;
				ICMC_IDX_MASK:   next_r.rdata[ICMC_EV_W-1:0] = r.mask;
				default: ;
			endcase
		end
		next_r.irq = |(next_r.stat & next_r.mask);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	always_ff @(posedge clk_i) begin
		if (do_push) buf_mem[r.wp] <= r.timer;
	end

	assign rdata_o = r.rdata;
	assign irq_o = r.irq;
	assign wake_o = r.wake;

	// assertions
	off_no_cap_a: assert property (@(posedge clk_i) disable iff (rst_i)
		r.mode == ICMC_M_OFF |=> !$rose(r.stat[ICMC_EV_CAPIRQ]))
		else $error("capture irq while off");
	wake_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
		r.mode == ICMC_M_WAKE |-> !do_push)
		else $error("capture in wake mode");
	wake_rise_a: assert property (@(posedge clk_i) disable iff (rst_i)
		r.mode == ICMC_M_WAKE && cap_in_i && !r.in_d && sleep_i |=> wake_o)
		else $error("wake missed");
	bne_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i && addr_i == ICMC_IDX_CON1 |=> rdata_o[ICMC_BNE_BIT] == ($past(r.cnt) != 3'h0))
		else $error("nonempty flag wrong");
	ovf_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i && addr_i == ICMC_IDX_CON1 |=> rdata_o[ICMC_OVF_BIT] == $past(r.ovf))
		else $error("overflow flag wrong");
	ovf_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cap && r.cnt == 3'(DEPTH) && !(wr_i && addr_i == ICMC_IDX_CON1) |=> r.ovf)
		else $error("overflow not set");
	every_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
		r.mode == ICMC_M_BOTH && cap |=> r.stat[ICMC_EV_CAPIRQ])
		else $error("every-edge irq missed");
	cpi_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cap && r.mode != ICMC_M_BOTH && r.irqcnt != r.cpi && !(wr_i && addr_i == ICMC_IDX_CON1)
		|=> r.irqcnt == $past(r.irqcnt) + 2'h1)
		else $error("capture count wrong");
	fall_cap_a: assert property (@(posedge clk_i) disable iff (rst_i)
		r.mode == ICMC_M_FALL && !cap_in_i && r.in_d |-> cap)
		else $error("falling edge missed");
	periph_tick_a: assert property (@(posedge clk_i) disable iff (rst_i)
		r.tsel == ICMC_TB_PERIPH && !r.trig && !sync_src_i && !(wr_i && addr_i == ICMC_IDX_CON1)
		|=> r.timer == $past(r.timer) + 16'h0001)
		else $error("timebase not counting");
	trig_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		r.trig && !r.tstat |=> r.timer == 16'h0000)
		else $error("timer ran before trigger");
	cap_c: cover property (@(posedge clk_i) disable iff (rst_i) do_push);
	ovf_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(r.ovf));
	irq_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
	wake_c: cover property (@(posedge clk_i) disable iff (rst_i) wake_o);
	trig_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(r.tstat));

endmodule : icmc_core

/* File: pkg/icmc_pkg.sv */
// package for the input capture mode control block
package icmc_pkg;

	// register word indices (byte address = index * 4)
	localparam logic [3:0] ICMC_IDX_CON1   = 4'h0;
	localparam logic [3:0] ICMC_IDX_CON2   = 4'h1;
	localparam logic [3:0] ICMC_IDX_BUF    = 4'h2;
	localparam logic [3:0] ICMC_IDX_STATUS = 4'h3;
	localparam logic [3:0] ICMC_IDX_MASK   = 4'h4;

	// control one field positions
	localparam int ICMC_MODE_LSB  = 0;
	localparam int ICMC_BNE_BIT   = 3;
	localparam int ICMC_OVF_BIT   = 4;
	localparam int ICMC_CPI_LSB   = 5;
	localparam int ICMC_TSEL_LSB  = 10;
	// control two field positions
	localparam int ICMC_TRIG_BIT  = 7;
	localparam int ICMC_TSTAT_BIT = 6;

	// capture modes
	localparam logic [2:0] ICMC_M_OFF   = 3'h0;
	localparam logic [2:0] ICMC_M_BOTH  = 3'h1;
	localparam logic [2:0] ICMC_M_FALL  = 3'h2;
	localparam logic [2:0] ICMC_M_RISE  = 3'h3;
	localparam logic [2:0] ICMC_M_RISE4 = 3'h4;
	localparam logic [2:0] ICMC_M_RISE16 = 3'h5;
	localparam logic [2:0] ICMC_M_WAKE  = 3'h7;

	// timebase codes
	localparam logic [2:0] ICMC_TB_PERIPH = 3'h7;
	localparam logic [2:0] ICMC_TB_TCLK1  = 3'h4;
	localparam logic [2:0] ICMC_TB_TCLK2  = 3'h1;

	// prescaler terminal counts
	localparam logic [3:0] ICMC_PRE4_LAST  = 4'h3;
	localparam logic [3:0] ICMC_PRE16_LAST = 4'hf;

	// status/mask bit positions
	localparam int ICMC_EV_CAPIRQ = 0;
	localparam int ICMC_EV_OVF    = 1;
	localparam int ICMC_EV_WAKE   = 2;
	localparam int ICMC_EV_W      = 3;

	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} icmc_bus_s;

	typedef struct packed {
		logic        in_d;
		logic [2:0]  mode;
		logic [1:0]  cpi;
		logic [2:0]  tsel;
		logic        trig;
		logic        tstat;
		logic [3:0]  pre;
		logic [1:0]  irqcnt;
		logic [2:0]  cnt;
		logic [1:0]  wp;
		logic [1:0]  rp;
		logic        ovf;
		logic [15:0] timer;
		logic [ICMC_EV_W-1:0] stat;
		logic [ICMC_EV_W-1:0] mask;
		logic [15:0] rdata;
		logic        irq;
		logic        wake;
	} icmc_state_s;

endpackage : icmc_pkg

/* File: verification/icmc_edge_src.sv */
// partner model: external input line that sends bursts of pulses
`timescale 1ns/1ps
module icmc_edge_src (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// burst request
	input  wire logic       go_i,
	input  wire logic [4:0] count_i,
	// capture line and status
	output logic            cap_o,
	output logic            busy_o
);
	logic [6:0] ph;
	wire  logic [6:0] nph = ph - 7'h01;
	// two cycles high, two low per pulse; line rests low between bursts
	always_ff @(posedge clk_i) begin
		if (rst_i || (go_i && !busy_o)) begin
			ph     <= rst_i ? 7'h00 : {count_i, 2'h0};
			busy_o <= !rst_i && (count_i != 5'h00);
			cap_o  <= 1'b0;
		end else if (busy_o) begin
			ph     <= nph;
			cap_o  <= nph[1];
			busy_o <= nph != 7'h00;
		end
	end
endmodule : icmc_edge_src

/* File: verification/icmc_bench.sv */
// self-checking bench for the input capture mode control block
`timescale 1ns/1ps
module icmc_bench;
	import icmc_pkg::*;
	logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, sync = 1'b0, sleep = 1'b0;
	logic        go = 1'b0, cap, busy, irq, wake, wake_seen = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [15:0] wdata = 16'h0000, rdata, got, con, t0;
	logic [4:0]  count = 5'h00;
	logic [1:0]  tc = 2'h0;
	int          err_count = 0, n_compared = 0, k;
	always #25 clk = ~clk;
	always @(posedge clk) tc <= tc + 2'h1;
	always @(posedge clk) if (wake) wake_seen <= 1'b1;
	icmc_core DUT (.clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .cap_in_i(cap), .tclk1_tick_i(tc == 2'h0), .tclk2_tick_i(tc[0]),
		.sync_src_i(sync), .sleep_i(sleep), .irq_o(irq), .wake_o(wake));
	icmc_edge_src src (.clk_i(clk), .rst_i(rst), .go_i(go), .count_i(count), .cap_o(cap), .busy_o(busy));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic end_sim;
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_sim
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1 got = rdata;
	endtask : rd_reg
	task automatic burst(input logic [4:0] n);
		int i;
		@(posedge clk);
		count <= n;
		go    <= 1'b1;
		@(posedge clk);
		go    <= 1'b0;
		for (i = 0; i < 200 && (busy || i < 2); i++) @(posedge clk);
		if (busy) begin
			err_count++;
			end_sim();
		end
		repeat (4) @(posedge clk);
	endtask : burst
	// flush, clear status, then set control one
	task automatic setup(input logic [15:0] c);
		wr_reg(ICMC_IDX_CON1, 16'h0000);
		wr_reg(ICMC_IDX_STATUS, 16'h0007);
		wr_reg(ICMC_IDX_CON1, c);
		con = c;
	endtask : setup
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd_reg(ICMC_IDX_CON1);
		chk(got, 16'h0000);
		rd_reg(4'h9);
		chk(got, 16'h0000);
		burst(5'h02);
		rd_reg(ICMC_IDX_CON1);
		chk(got, 16'h0000);
		rd_reg(ICMC_IDX_STATUS);
		chk(got, 16'h0000);
		wr_reg(ICMC_IDX_MASK, 16'h0007);
		for (k = 0; k < 4; k++) begin
			setup(16'(ICMC_M_RISE) | 16'(k << ICMC_CPI_LSB));
			burst(5'(k));
			chk({15'h0000, irq}, 16'h0000);
			burst(5'h01);
			chk({15'h0000, irq}, 16'h0001);
			rd_reg(ICMC_IDX_CON1);
			chk(got, con | 16'h0008);
		end
		repeat (4) rd_reg(ICMC_IDX_BUF);
		rd_reg(ICMC_IDX_CON1);
		chk(got, con);
		wr_reg(ICMC_IDX_MASK, 16'h0000);
		@(posedge clk);
		chk({15'h0000, irq}, 16'h0000);
		wr_reg(ICMC_IDX_MASK, 16'h0007);
		@(posedge clk);
		chk({15'h0000, irq}, 16'h0001);
		wr_reg(ICMC_IDX_STATUS, 16'h0001);
		@(posedge clk);
		chk({15'h0000, irq}, 16'h0000);
		setup(16'(ICMC_M_BOTH) | 16'h0060);
		burst(5'h01);
		rd_reg(ICMC_IDX_STATUS);
		chk(got, 16'h0001);
		burst(5'h02);
		rd_reg(ICMC_IDX_CON1);
		chk(got, con | 16'h0018);
		for (k = 0; k < 3; k++) begin
			setup(16'(k == 0 ? ICMC_M_FALL : k == 1 ? ICMC_M_RISE4 : ICMC_M_RISE16));
			burst(k == 0 ? 5'h00 : k == 1 ? 5'h03 : 5'h0f);
			rd_reg(ICMC_IDX_CON1);
			chk(got, con);
			burst(5'h01);
			rd_reg(ICMC_IDX_CON1);
			chk(got, con | 16'h0008);
		end
		setup(16'(ICMC_M_WAKE));
		sleep     <= 1'b1;
		burst(5'h01);
		chk({15'h0000, wake_seen}, 16'h0001);
		rd_reg(ICMC_IDX_CON1);
		chk(got, con);
		rd_reg(ICMC_IDX_STATUS);
		chk(got, 16'h0004);
		sleep <= 1'b0;
		for (k = 0; k < 3; k++) begin
			con = 16'(k == 0 ? ICMC_TB_PERIPH : k == 1 ? ICMC_TB_TCLK1 : ICMC_TB_TCLK2) << ICMC_TSEL_LSB;
			wr_reg(ICMC_IDX_CON1, con);
			rd_reg(ICMC_IDX_CON1);
			chk(got, con);
			setup(con | 16'(ICMC_M_RISE));
			burst(5'h02);
			rd_reg(ICMC_IDX_BUF);
			t0 = got;
			rd_reg(ICMC_IDX_BUF);
			chk(got - t0, k == 0 ? 16'h0004 : k == 1 ? 16'h0001 : 16'h0002);
		end
		// sync pulse clears the timer; first rise lands three ticks later
		setup(16'(ICMC_M_RISE) | (16'(ICMC_TB_PERIPH) << ICMC_TSEL_LSB));
		sync <= 1'b1;
		@(posedge clk);
		sync <= 1'b0;
		burst(5'h01);
		rd_reg(ICMC_IDX_BUF);
		chk(got, 16'h0003);
		wr_reg(ICMC_IDX_CON2, 16'h0080);
		sync <= 1'b1;
		@(posedge clk);
		sync <= 1'b0;
		repeat (2) @(posedge clk);
		rd_reg(ICMC_IDX_CON2);
		chk(got, 16'h00c0);
		end_sim();
	end
endmodule : icmc_bench
